// File: hw/amd_pkg.sv
// Shared types and constants for the addressing-mode decoder.
package amd_pkg;

    typedef enum logic [3:0] {
        bit_test_branch_class,
        bit_set_clear_class,
        pc_relative_class,
        direct_class,
        inherent_class,
        immediate_class,
        extended_class,
        indexed_word_offset_class,
        indexed_byte_offset_class,
        indexed_no_offset_class
    } amd_class_e;

    // Decode result handed from the opcode classifier to the sequencer.
    typedef struct packed {
        amd_class_e op_class;
        logic implemented;
        logic [1:0] length;
    } amd_decode_s;

    // Result of one decoded instruction.
    typedef struct packed {
        logic [7:0] opcode;
        amd_class_e op_class;
        logic illegal;
        logic ea_valid;
        logic [15:0] effective_address;
        logic [7:0] operand;
        logic [15:0] next_pc;
    } amd_result_s;

    // One bit per low nibble; a set bit marks an occupied opcode-map cell.
    localparam logic [15:0] MAP_FULL = 16'hFFFF;
    localparam logic [15:0] MAP_RMW_MEM = 16'hB7D9;
    localparam logic [15:0] MAP_RMW_ACC = 16'hB7DD;
    localparam logic [15:0] MAP_CTRL_LO = 16'hC00B;
    localparam logic [15:0] MAP_CTRL_HI = 16'hBF80;
    localparam logic [15:0] MAP_IMM = 16'h6F7F;

    // The only relative-branch cell outside the branch column.
    localparam logic [3:0] IMM_COL_BRANCH_ROW = 4'hD;

    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    localparam logic [15:0] PC_STEP_ONE = 16'h0001;
    localparam logic [15:0] PC_STEP_TWO = 16'h0002;
    localparam logic [15:0] PC_STEP_THREE = 16'h0003;

    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [6:0] CARRY_PAD = 7'h00;

endpackage

// File: hw/amd_opclass.sv
// Opcode-map classifier: addressing class, length and legality of one opcode.
`timescale 1ns/100ps
module amd_opclass (
    input wire logic [7:0] opcode_i,
    output amd_pkg::amd_decode_s decode_o
);

    logic [3:0] col;
    logic [3:0] row;
    logic [15:0] occupied;

    assign col = opcode_i[7:4];
    assign row = opcode_i[3:0];

    // High nibble picks the column, low nibble the cell within it.
    always_comb begin
        decode_o.op_class = amd_pkg::inherent_class;
        decode_o.length = amd_pkg::LEN_ONE;
        occupied = amd_pkg::MAP_FULL;
        unique case (col)
            4'h0: begin
                decode_o.op_class = amd_pkg::bit_test_branch_class;
                decode_o.length = amd_pkg::LEN_THREE;
            end
            4'h1: begin
                decode_o.op_class = amd_pkg::bit_set_clear_class;
                decode_o.length = amd_pkg::LEN_TWO;
            end
            4'h2: begin
                decode_o.op_class = amd_pkg::pc_relative_class;
                decode_o.length = amd_pkg::LEN_TWO;
            end
            4'h3: begin
                decode_o.op_class = amd_pkg::direct_class;
                decode_o.length = amd_pkg::LEN_TWO;
                occupied = amd_pkg::MAP_RMW_MEM;
            end
            4'h4: begin
                occupied = amd_pkg::MAP_RMW_ACC;
            end
            4'h5: begin
                occupied = amd_pkg::MAP_RMW_MEM;
            end
            4'h6: begin
                decode_o.op_class = amd_pkg::indexed_byte_offset_class;
                decode_o.length = amd_pkg::LEN_TWO;
                occupied = amd_pkg::MAP_RMW_MEM;
            end
            4'h7: begin
                decode_o.op_class = amd_pkg::indexed_no_offset_class;
                occupied = amd_pkg::MAP_RMW_MEM;
            end
            4'h8: begin
                occupied = amd_pkg::MAP_CTRL_LO;
            end
            4'h9: begin
                occupied = amd_pkg::MAP_CTRL_HI;
            end
            4'hA: begin
                decode_o.length = amd_pkg::LEN_TWO;
                occupied = amd_pkg::MAP_IMM;
                if (row == amd_pkg::IMM_COL_BRANCH_ROW) begin
                    decode_o.op_class = amd_pkg::pc_relative_class;
                end else begin
                    decode_o.op_class = amd_pkg::immediate_class;
                end
            end
            4'hB: begin
                decode_o.op_class = amd_pkg::direct_class;
                decode_o.length = amd_pkg::LEN_TWO;
            end
            4'hC: begin
                decode_o.op_class = amd_pkg::extended_class;
                decode_o.length = amd_pkg::LEN_THREE;
            end
            4'hD: begin
                decode_o.op_class = amd_pkg::indexed_word_offset_class;
                decode_o.length = amd_pkg::LEN_THREE;
            end
            4'hE: begin
                decode_o.op_class = amd_pkg::indexed_byte_offset_class;
                decode_o.length = amd_pkg::LEN_TWO;
            end
            4'hF: begin
                decode_o.op_class = amd_pkg::indexed_no_offset_class;
            end
        endcase
        decode_o.implemented = occupied[row];
    end

endmodule

// File: hw/amd_decoder.sv
// Effective-address generation and operand-fetch sequencing for the CPU core.
`timescale 1ns/100ps
module amd_decoder (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] index_i,
    input wire logic [7:0] mem_rdata_i,
    output logic mem_rd_o,
    output logic [15:0] mem_addr_o,
    output logic busy_o,
    output logic done_o,
    output amd_pkg::amd_result_s result_o
);

    typedef enum logic [1:0] {
        AMD_IDLE,
        AMD_OPCODE,
        AMD_BYTE1,
        AMD_BYTE2
    } amd_state_e;

    amd_state_e state;
    logic [15:0] pc;
    logic [7:0] index;
    logic [7:0] opcode;
    logic [7:0] byte1;
    amd_pkg::amd_decode_s dec;
    amd_pkg::amd_decode_s live_dec;
    logic [8:0] ix_sum;

    // Program-counter arithmetic shared by the operand fetch addresses, the immediate address and every next-PC computation.
    function automatic logic [15:0] pc_add(input logic [15:0] base, input logic [15:0] step);
        return 16'(base + step);
    endfunction

    // Length as a program-counter step.
    function automatic logic [15:0] len_step(input logic [1:0] len);
        logic [15:0] step;
        step = amd_pkg::PC_STEP_ONE;
        if (len == amd_pkg::LEN_TWO) begin
            step = amd_pkg::PC_STEP_TWO;
        end else if (len == amd_pkg::LEN_THREE) begin
            step = amd_pkg::PC_STEP_THREE;
        end
        return step;
    endfunction

    amd_opclass u_opclass (
        .opcode_i(mem_rdata_i),
        .decode_o(live_dec)
    );

    // Unsigned sum; bit 8 is the carry that becomes the address high byte.
    assign ix_sum = {1'b0, index} + {1'b0, mem_rdata_i};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= AMD_IDLE;
        end else begin
            unique case (state)
                AMD_IDLE: begin
                    if (start_i) begin
                        state <= AMD_OPCODE;
                    end
                end
                AMD_OPCODE: begin
                    // Anything shorter than two bytes is finished on the opcode alone.
                    if (live_dec.implemented && live_dec.length != amd_pkg::LEN_ONE) begin
                        state <= AMD_BYTE1;
                    end else begin
                        state <= AMD_IDLE;
                    end
                end
                AMD_BYTE1: begin
                    if (dec.op_class == amd_pkg::extended_class) begin
                        state <= AMD_BYTE2;
                    end else begin
                        state <= AMD_IDLE;
                    end
                end
                AMD_BYTE2: begin
                    state <= AMD_IDLE;
                end
            endcase
        end
    end

    // Context is latched at start so the core may change PC and X meanwhile.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc <= 16'h0000;
            index <= 8'h00;
            opcode <= 8'h00;
            byte1 <= 8'h00;
            dec <= '0;
        end else begin
            if (state == AMD_IDLE && start_i) begin
                pc <= pc_i;
                index <= index_i;
            end
            if (state == AMD_OPCODE) begin
                opcode <= mem_rdata_i;
                dec <= live_dec;
            end
            if (state == AMD_BYTE1) begin
                byte1 <= mem_rdata_i;
            end
        end
    end

    // Memory reads: opcode at PC, then PC+1 and for the extended form PC+2.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_rd_o <= 1'b0;
            mem_addr_o <= 16'h0000;
        end else begin
            mem_rd_o <= 1'b0;
            if (state == AMD_IDLE && start_i) begin
                mem_rd_o <= 1'b1;
                mem_addr_o <= pc_i;
            end else if (state == AMD_OPCODE && live_dec.implemented
                    && live_dec.length != amd_pkg::LEN_ONE) begin
                mem_rd_o <= 1'b1;
                mem_addr_o <= pc_add(pc, amd_pkg::PC_STEP_ONE);
            end else if (state == AMD_BYTE1 && dec.op_class == amd_pkg::extended_class) begin
                mem_rd_o <= 1'b1;
                mem_addr_o <= pc_add(pc, amd_pkg::PC_STEP_TWO);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state == AMD_IDLE) ? start_i
                : !(state == AMD_BYTE2 || (state == AMD_BYTE1
                && dec.op_class != amd_pkg::extended_class)
                || (state == AMD_OPCODE && (!live_dec.implemented
                || live_dec.length == amd_pkg::LEN_ONE)));
        end
    end

    // Result is published with a one-cycle done pulse and held until the next one.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_o <= 1'b0;
            result_o <= '0;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                AMD_IDLE: begin
                end
                AMD_OPCODE: begin
                    if (!live_dec.implemented || live_dec.length == amd_pkg::LEN_ONE) begin
                        done_o <= 1'b1;
                        result_o.opcode <= mem_rdata_i;
                        result_o.op_class <= live_dec.op_class;
                        result_o.illegal <= !live_dec.implemented;
                        result_o.operand <= 8'h00;
                        // Illegal opcodes still step one byte so the core can trap.
                        result_o.next_pc <= pc_add(pc, amd_pkg::PC_STEP_ONE);
                        result_o.ea_valid <= 1'b0;
                        result_o.effective_address <= 16'h0000;
                        if (live_dec.implemented
                                && live_dec.op_class == amd_pkg::indexed_no_offset_class) begin
                            result_o.ea_valid <= 1'b1;
                            result_o.effective_address <= {amd_pkg::PAGE_ZERO, index};
                        end
                    end
                end
                AMD_BYTE1: begin
                    if (dec.op_class != amd_pkg::extended_class) begin
                        done_o <= 1'b1;
                        result_o.opcode <= opcode;
                        result_o.op_class <= dec.op_class;
                        result_o.illegal <= 1'b0;
                        result_o.operand <= mem_rdata_i;
                        result_o.next_pc <= pc_add(pc, len_step(dec.length));
                        result_o.ea_valid <= 1'b0;
                        result_o.effective_address <= 16'h0000;
                        if (dec.op_class == amd_pkg::immediate_class) begin
                            result_o.ea_valid <= 1'b1;
                            result_o.effective_address <= pc_add(pc, amd_pkg::PC_STEP_ONE);
                        end else if (dec.op_class == amd_pkg::direct_class) begin
                            result_o.ea_valid <= 1'b1;
                            result_o.effective_address <= {amd_pkg::PAGE_ZERO, mem_rdata_i};
                        end else if (dec.op_class == amd_pkg::indexed_byte_offset_class) begin
                            result_o.ea_valid <= 1'b1;
                            result_o.effective_address <= {amd_pkg::CARRY_PAD, ix_sum};
                        end
                    end
                end
                AMD_BYTE2: begin
                    done_o <= 1'b1;
                    result_o.opcode <= opcode;
                    result_o.op_class <= dec.op_class;
                    result_o.illegal <= 1'b0;
                    result_o.operand <= byte1;
                    result_o.next_pc <= pc_add(pc, amd_pkg::PC_STEP_THREE);
                    result_o.ea_valid <= 1'b1;
                    // Full 16 bits, so a jump can land anywhere in memory.
                    result_o.effective_address <= {byte1, mem_rdata_i};
                end
            endcase
        end
    end

endmodule

// File: dv/amd_decoder_properties.sv
// Concurrent checks on the ports of the addressing-mode decoder.
`timescale 1ns/100ps
module amd_decoder_properties (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] index_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_rd_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire amd_pkg::amd_result_s result_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_take;
        start_i && !busy_o;
    endsequence
    // Matches on the edge that captures the opcode byte of a taken decode.
    sequence s_opcode(logic [7:0] op);
        s_take ##1 (mem_rd_o && mem_rdata_i == op);
    endsequence

    property p_fetch_first;
        s_take |-> ##1 (mem_rd_o && busy_o && mem_addr_o == $past(pc_i));
    endproperty
    a_fetch_first: assert property (p_fetch_first)
        else $error("opcode fetch missing or misaddressed");
    property p_seq_addr;
        mem_rd_o && $past(mem_rd_o) |-> mem_addr_o == $past(mem_addr_o) + 16'h0001;
    endproperty
    a_seq_addr: assert property (p_seq_addr)
        else $error("operand bytes not fetched in ascending order");
    property p_ext;
        s_opcode(8'hC6) |-> ##3 (done_o && result_o.ea_valid
            && result_o.effective_address == {$past(mem_rdata_i, 2), $past(mem_rdata_i)}
            && result_o.next_pc == mem_addr_o + 16'h0001);
    endproperty
    a_ext: assert property (p_ext)
        else $error("extended address or length wrong");
    property p_direct;
        s_opcode(8'hB6) |-> ##2 (done_o
            && result_o.effective_address == {8'h00, $past(mem_rdata_i)}
            && result_o.next_pc == mem_addr_o + 16'h0001);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct address or length wrong");
    property p_imm;
        s_opcode(8'hA6) |-> ##2 (done_o && result_o.effective_address == mem_addr_o
            && result_o.operand == $past(mem_rdata_i)
            && result_o.next_pc == mem_addr_o + 16'h0001);
    endproperty
    a_imm: assert property (p_imm)
        else $error("immediate operand or length wrong");
    property p_ix1;
        s_opcode(8'hE6) |-> ##2 (done_o && result_o.effective_address
            == {8'h00, $past(index_i, 3)} + {8'h00, $past(mem_rdata_i)});
    endproperty
    a_ix1: assert property (p_ix1)
        else $error("byte offset index sum wrong");
    property p_ix;
        s_opcode(8'hF6) |-> ##1 (done_o
            && result_o.effective_address == {8'h00, $past(index_i, 2)}
            && result_o.next_pc == $past(pc_i, 2) + 16'h0001);
    endproperty
    a_ix: assert property (p_ix)
        else $error("plain indexed address or length wrong");
    property p_inh;
        s_opcode(8'h4C) |-> ##1 (done_o && !result_o.ea_valid && !result_o.illegal
            && result_o.op_class == amd_pkg::inherent_class
            && result_o.next_pc == $past(pc_i, 2) + 16'h0001);
    endproperty
    a_inh: assert property (p_inh)
        else $error("inherent decode wrong");
    property p_illegal;
        s_opcode(8'h31) |-> ##1 (done_o && result_o.illegal && !result_o.ea_valid
            && result_o.next_pc == mem_addr_o + 16'h0001);
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("empty map cell not flagged");
    property p_done_pulse;
        done_o |-> !busy_o ##1 !done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done is not a single pulse with busy low");
endmodule

bind amd_decoder amd_decoder_properties u_props (.clk_i(clk_i), .rstn_i(rstn_i),
    .start_i(start_i), .pc_i(pc_i), .index_i(index_i), .mem_rdata_i(mem_rdata_i),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .busy_o(busy_o), .done_o(done_o),
    .result_o(result_o));

// File: dv/amd_decoder_tb.sv
// Self-checking testbench for the addressing-mode decoder.
`timescale 1ns/100ps
module amd_decoder_tb;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic start_i = 1'b0;
    logic [15:0] pc_i = 16'h0000;
    logic [7:0] index_i = 8'h00;
    logic [7:0] mem_rdata_i = 8'h00;
    logic mem_rd_o;
    logic [15:0] mem_addr_o;
    logic busy_o;
    logic done_o;
    amd_pkg::amd_result_s result_o;
    int errors = 0;
    int checks_done = 0;
    logic [7:0] cur_op = 8'h00;
    logic [7:0] cur_b1 = 8'h00;
    logic [15:0] cur_pc = 16'h0000;
    // Each row packs opcode, index, first operand byte, class code and illegal flag.
    logic [31:0] rows [0:20] = '{32'h4C112240, 32'h9D112240, 32'h8E112240, 32'hA6335A50,
        32'hAD335A20, 32'hB600FF30, 32'h3C448030, 32'hC6551260, 32'hCC66FF60, 32'hD6771070,
        32'hE6FFFF80, 32'h6C808080, 32'hF6A50190, 32'h7C000190, 32'h10123410, 32'h01123400,
        32'h20123420, 32'h31123431, 32'h82123441, 32'hAC123451, 32'h9E123441};

    amd_decoder DUT (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .pc_i(pc_i),
        .index_i(index_i), .mem_rdata_i(mem_rdata_i), .mem_rd_o(mem_rd_o),
        .mem_addr_o(mem_addr_o), .busy_o(busy_o), .done_o(done_o), .result_o(result_o));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        if (a == cur_pc) return cur_op;
        if (a == cur_pc + 16'h0001) return cur_b1;
        if (a == cur_pc + 16'h0002) return cur_b1 ^ 8'h26;
        return a[7:0] ^ a[15:8];
    endfunction

    // Idle data toggles every cycle, so a decoder sampling off the read cycle sees junk.
    always @(negedge clk_i) begin
        if (mem_rd_o === 1'b1) begin
            mem_rdata_i <= mem_byte(mem_addr_o);
        end else begin
            mem_rdata_i <= ~mem_rdata_i;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Called at a falling edge; returns at the falling edge inside the done cycle.
    task automatic run(input logic [31:0] r, input logic [15:0] pc, input logic poke);
        int n;
        logic ev;
        logic [1:0] len;
        logic [15:0] ea;
        amd_pkg::amd_class_e cls;
        n = 0;
        ev = 1'b1;
        ea = 16'h0000;
        cls = amd_pkg::amd_class_e'(r[7:4]);
        cur_op = r[31:24];
        cur_pc = pc;
        cur_b1 = r[15:8];
        start_i = 1'b1;
        pc_i = pc;
        index_i = r[23:16];
        @(negedge clk_i);
        pc_i = ~pc;
        index_i = ~r[23:16];
        start_i = 1'b0;
        while (done_o !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
            start_i = poke && (n == 1);
        end
        case (cls)
            amd_pkg::immediate_class: ea = pc + 16'h0001;
            amd_pkg::direct_class: ea = {8'h00, r[15:8]};
            amd_pkg::extended_class: ea = {r[15:8], r[15:8] ^ 8'h26};
            amd_pkg::indexed_no_offset_class: ea = {8'h00, r[23:16]};
            amd_pkg::indexed_byte_offset_class: ea = {8'h00, r[23:16]} + {8'h00, r[15:8]};
            default: ev = 1'b0;
        endcase
        if (cls inside {amd_pkg::extended_class, amd_pkg::indexed_word_offset_class,
                amd_pkg::bit_test_branch_class}) len = 2'h3;
        else if (cls inside {amd_pkg::inherent_class, amd_pkg::indexed_no_offset_class}) len = 2'h1;
        else len = 2'h2;
        if (r[0]) begin
            ev = 1'b0;
            len = 2'h1;
        end
        // The count starts one falling edge after the taking edge, so done lands one lower.
        check(n, (len == 2'h1) ? 1 : (cls == amd_pkg::extended_class) ? 3 : 2);
        check(result_o.opcode, r[31:24]);
        check(result_o.op_class, r[7:4]);
        check(result_o.illegal, r[0]);
        check(result_o.ea_valid, ev);
        check(result_o.next_pc, pc + {14'h0000, len});
        if (ev) check(result_o.effective_address, ea);
        if (len != 2'h1 && !(cls inside {amd_pkg::direct_class,
                amd_pkg::indexed_byte_offset_class})) check(result_o.operand, r[15:8]);
    endtask

    initial begin
        repeat (4) @(negedge clk_i);
        check({mem_rd_o, busy_o, done_o, result_o}, 64'h0);
        rstn_i = 1'b1;
        for (int i = 0; i < 21; i++) begin
            run(rows[i], 16'h0C35 * i[15:0] + 16'h0100, 1'b0);
        end
        run(rows[7], 16'hFFF0, 1'b1);
        cur_op = 8'hC6;
        cur_pc = 16'h4000;
        start_i = 1'b1;
        pc_i = 16'h4000;
        @(negedge clk_i);
        start_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check(busy_o, 1'b1);
        rstn_i = 1'b0;
        @(negedge clk_i);
        check({mem_rd_o, busy_o, done_o, result_o}, 64'h0);
        rstn_i = 1'b1;
        run(rows[10], 16'h01F0, 1'b0);
        summarize();
    end

    // A hung handshake ends the run well past the under a hundred cycles the tests need.
    initial begin
        #(4000 * 25);
        errors++;
        summarize();
    end
endmodule
